// file: rtl/cospd_map.svh
`ifndef COSPD_MAP_SVH
`define COSPD_MAP_SVH

// ----------------------------------------
// Management bus addressing
// ----------------------------------------
`define COSPD_SLAVE_ADDR 7'h69
`define COSPD_REG_DRIVE 8'h05
`define COSPD_REG_TEST 8'h06
`define COSPD_REG_IDENT 8'h07
`define COSPD_BYTE_BITS 4'h8

// ----------------------------------------
// Field positions
// ----------------------------------------
`define COSPD_B5_STOP_HIZ 7
`define COSPD_B5_REF_DOWN_HIZ 3
`define COSPD_B6_REF_DIV 7
`define COSPD_B6_TEST_EN 6
`define COSPD_B6_REF_STRONG 4
`define COSPD_B6_STOP_N 3

// ----------------------------------------
// Reset values and write masks
// ----------------------------------------
`define COSPD_B5_RESET 8'h00
`define COSPD_B6_RESET 8'h18
`define COSPD_B5_WMASK 8'h8F
`define COSPD_B6_WMASK 8'hD8
// Identity codes: arbitrary values
`define COSPD_REV_CODE 4'h5
`define COSPD_MAKER_CODE 4'hA

// ----------------------------------------
// Timing
// ----------------------------------------
`define COSPD_CLK_NS 20
`define COSPD_LATENCY_NS 1800000
`define COSPD_DOWN_EDGES 2'h2
`define COSPD_WAIT_W 17
`define COSPD_NUM_STOPPABLE 10

`endif

// file: rtl/cospd_pkg.sv
package cospd_pkg;

    typedef enum logic [2:0] {
        PWR_WAIT_GOOD,
        PWR_WAKE,
        PWR_RUN,
        PWR_HOLD,
        PWR_PARKED,
        PWR_OFF
    } cospd_pwr_t;

    typedef enum logic [2:0] {
        SMB_IDLE,
        SMB_ADDR,
        SMB_CMD,
        SMB_DATA,
        SMB_TX,
        SMB_SKIP
    } cospd_smb_t;

endpackage : cospd_pkg

// file: rtl/cospd_ctrl.sv
`timescale 1ns/1ps
`include "cospd_map.svh"
// Operation
// - Byte5 bit7: bus-reference stop drive or high-Z
// - Byte5 bit3: bus-reference power-down drive mode
// - Byte5 bits2-0: processor pair power-down mode
// - Byte6 bit7: test divided clock or high-Z
// - Byte6 bit6 enters test clock mode
// - Byte6 bit4 sets crystal-copy drive strength
// - Writing bit3 low stops stoppable outputs cleanly
// - Writing bit3 high restarts stopped outputs cleanly
// - Byte6 bits2-0 show latched frequency selects
// - Byte7 reads revision and maker codes
// - Shared pin: power-good first, then power-down
// - Power-down input synchronised before use
// - Park clocks before oscillators switch off
// - Two complement rises high recognise power-down
// - Park pairs at next complement fall
// - Driven mode parks true high, complement off
// - Stable clocks within 1.8 ms of wake
// - High-Z pairs driven high soon after wake
// - All outputs enabled together after lock or lock timeout
// - Byte write: address, command, data, acks
// - Stop affects only outputs marked stoppable
module cospd_ctrl #(
    parameter int LATENCY_CYC = `COSPD_LATENCY_NS / `COSPD_CLK_NS
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic smb_clk,
    input wire logic smb_data_in,
    output logic smb_data_out,
    output logic smb_data_oe,
    input wire logic supply_good_strobe,
    input wire logic processor_complement_clock,
    input wire logic pll_lock,
    input wire logic freq_select_a,
    input wire logic freq_select_b,
    input wire logic freq_select_c,
    input wire logic [`COSPD_NUM_STOPPABLE-1:0] bus_clk_stoppable,
    output logic [`COSPD_NUM_STOPPABLE-1:0] bus_clk_stop_gate,
    output logic bus_clock_stop_request,
    output logic bus_ref_stop_hiz,
    output logic [2:0] cpu_diff_park,
    output logic [2:0] cpu_diff_hiz,
    output logic bus_ref_park,
    output logic bus_ref_hiz,
    output logic single_ended_hold_low,
    output logic osc_enable,
    output logic pll_enable,
    output logic clocks_enable,
    output logic power_down_state,
    output logic test_mode_active,
    output logic test_ref_div_sel,
    output logic ref_drive_high
);

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic [2:0] scl_q;
    logic [2:0] sda_q;
    logic [1:0] pin_q;
    logic [1:0] lock_q;
    logic [2:0] cmpl_q;
    logic [2:0] fs_m;
    logic [2:0] fs_s;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
            pin_q <= 2'h3;
            lock_q <= 2'h0;
            cmpl_q <= 3'h0;
            fs_m <= 3'h0;
            fs_s <= 3'h0;
        end
        else
        begin
            scl_q <= {scl_q[1:0], smb_clk};
            sda_q <= {sda_q[1:0], smb_data_in};
            pin_q <= {pin_q[0], supply_good_strobe};
            lock_q <= {lock_q[0], pll_lock};
            cmpl_q <= {cmpl_q[1:0], processor_complement_clock};
            fs_m <= {freq_select_c, freq_select_b, freq_select_a};
            fs_s <= fs_m;
        end
    end

    logic pin_s;
    logic cmpl_rise;
    logic cmpl_fall;
    logic start_cond;
    logic stop_cond;
    logic scl_rise;
    logic scl_fall;
    assign pin_s = pin_q[1];
    assign cmpl_rise = cmpl_q[1] & ~cmpl_q[2];
    assign cmpl_fall = ~cmpl_q[1] & cmpl_q[2];
    assign start_cond = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
    assign stop_cond = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
    assign scl_rise = scl_q[1] & ~scl_q[2];
    assign scl_fall = ~scl_q[1] & scl_q[2];

    // ----------------------------------------
    // Management bus slave
    // ----------------------------------------
    cospd_pkg::cospd_smb_t smb;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic [3:0] bitcnt;
    logic ack_phase;
    logic wr_strobe;
    logic [7:0] wr_data;
    logic [7:0] rd_byte;

    // Open drain: only ever pulls low
    assign smb_data_out = 1'b0;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            smb <= cospd_pkg::SMB_IDLE;
            shreg <= 8'h00;
            ptr <= 8'h00;
            bitcnt <= 4'h0;
            ack_phase <= 1'b0;
            smb_data_oe <= 1'b0;
            wr_strobe <= 1'b0;
            wr_data <= 8'h00;
        end
        else
        begin
            wr_strobe <= 1'b0;
            if (start_cond)
            begin
                // Repeated start lands here too
                smb <= cospd_pkg::SMB_ADDR;
                bitcnt <= 4'h0;
                ack_phase <= 1'b0;
                smb_data_oe <= 1'b0;
            end
            else if (stop_cond)
            begin
                smb <= cospd_pkg::SMB_IDLE;
                ack_phase <= 1'b0;
                smb_data_oe <= 1'b0;
            end
            else if (scl_rise && !ack_phase && bitcnt != `COSPD_BYTE_BITS &&
                     smb != cospd_pkg::SMB_IDLE && smb != cospd_pkg::SMB_SKIP)
            begin
                // Transmit also shifts: next bit moves to the top
                shreg <= {shreg[6:0], sda_q[1]};
                bitcnt <= bitcnt + 4'h1;
            end
            else if (scl_fall)
            begin
                if (ack_phase)
                begin
                    ack_phase <= 1'b0;
                    bitcnt <= 4'h0;
                    smb_data_oe <= 1'b0;
                    unique case (smb)
                        cospd_pkg::SMB_ADDR:
                            if (shreg[0])
                            begin
                                smb <= cospd_pkg::SMB_TX;
                                shreg <= rd_byte;
                                smb_data_oe <= ~rd_byte[7];
                            end
                            else
                                smb <= cospd_pkg::SMB_CMD;
                        cospd_pkg::SMB_CMD: smb <= cospd_pkg::SMB_DATA;
                        cospd_pkg::SMB_DATA: smb <= cospd_pkg::SMB_SKIP;
                        cospd_pkg::SMB_TX: smb <= cospd_pkg::SMB_SKIP;
                        cospd_pkg::SMB_IDLE, cospd_pkg::SMB_SKIP: smb <= smb;
                    endcase
                end
                else if (bitcnt == `COSPD_BYTE_BITS)
                begin
                    ack_phase <= 1'b1;
                    unique case (smb)
                        cospd_pkg::SMB_ADDR:
                            if (shreg[7:1] == `COSPD_SLAVE_ADDR)
                                smb_data_oe <= 1'b1;
                            else
                            begin
                                smb <= cospd_pkg::SMB_SKIP;
                                ack_phase <= 1'b0;
                            end
                        cospd_pkg::SMB_CMD:
                        begin
                            ptr <= shreg;
                            smb_data_oe <= 1'b1;
                        end
                        cospd_pkg::SMB_DATA:
                        begin
                            wr_strobe <= 1'b1;
                            wr_data <= shreg;
                            smb_data_oe <= 1'b1;
                        end
                        cospd_pkg::SMB_TX: smb_data_oe <= 1'b0;
                        cospd_pkg::SMB_IDLE, cospd_pkg::SMB_SKIP: ack_phase <= 1'b0;
                    endcase
                end
                else if (smb == cospd_pkg::SMB_TX)
                    smb_data_oe <= ~shreg[7];
            end
        end
    end

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    cospd_pkg::cospd_pwr_t pwr;
    logic pg_load;
    logic [7:0] drive_mode_control;
    logic [7:0] test_and_stop_control;
    logic [2:0] fs_latch;

    assign pg_load = (pwr == cospd_pkg::PWR_WAIT_GOOD) && !pin_s;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            drive_mode_control <= `COSPD_B5_RESET;
            test_and_stop_control <= `COSPD_B6_RESET;
        end
        else if (pg_load)
        begin
            drive_mode_control <= `COSPD_B5_RESET;
            test_and_stop_control <= `COSPD_B6_RESET;
        end
        else if (wr_strobe && ptr == `COSPD_REG_DRIVE)
            drive_mode_control <= wr_data & `COSPD_B5_WMASK;
        else if (wr_strobe && ptr == `COSPD_REG_TEST)
            test_and_stop_control <= wr_data & `COSPD_B6_WMASK;
    end

    // Strap capture only at power-good, never under reset
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            fs_latch <= 3'h0;
        else if (pg_load)
            fs_latch <= fs_s;
    end

    always_comb
    begin
        unique case (ptr)
            `COSPD_REG_DRIVE: rd_byte = drive_mode_control;
            `COSPD_REG_TEST: rd_byte = test_and_stop_control | {5'h00, fs_latch};
            `COSPD_REG_IDENT: rd_byte = {`COSPD_REV_CODE, `COSPD_MAKER_CODE};
            default: rd_byte = 8'h00;
        endcase
    end

    // ----------------------------------------
    // Power sequencing
    // ----------------------------------------
    logic [1:0] down_cnt;
    logic [`COSPD_WAIT_W-1:0] wait_cnt;
    logic down_seen;
    assign down_seen = (down_cnt == `COSPD_DOWN_EDGES);

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            down_cnt <= 2'h0;
        else if (pwr != cospd_pkg::PWR_RUN)
            down_cnt <= 2'h0;
        else if (cmpl_rise)
            down_cnt <= !pin_s ? 2'h0 : (down_seen ? down_cnt : down_cnt + 2'h1);
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            wait_cnt <= '0;
        else if (pwr == cospd_pkg::PWR_WAKE)
            wait_cnt <= wait_cnt + `COSPD_WAIT_W'(1);
        else
            wait_cnt <= '0;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            pwr <= cospd_pkg::PWR_WAIT_GOOD;
        else
        begin
            unique case (pwr)
                cospd_pkg::PWR_WAIT_GOOD: if (pg_load) pwr <= cospd_pkg::PWR_WAKE;
                cospd_pkg::PWR_RUN: if (down_seen) pwr <= cospd_pkg::PWR_HOLD;
                cospd_pkg::PWR_HOLD: if (cmpl_fall) pwr <= cospd_pkg::PWR_PARKED;
                cospd_pkg::PWR_PARKED: pwr <= cospd_pkg::PWR_OFF;
                cospd_pkg::PWR_OFF: if (!pin_s) pwr <= cospd_pkg::PWR_WAKE;
                // Lock timeout caps latency if lock never shows
                cospd_pkg::PWR_WAKE:
                    if (lock_q[1] || wait_cnt == `COSPD_WAIT_W'(LATENCY_CYC - 1))
                        pwr <= cospd_pkg::PWR_RUN;
            endcase
        end
    end

    // ----------------------------------------
    // Output stage
    // ----------------------------------------
    logic stop_active;
    logic parked;
    logic hiz_phase;
    assign parked = pwr inside {cospd_pkg::PWR_PARKED, cospd_pkg::PWR_OFF, cospd_pkg::PWR_WAKE};
    // Wake drops high-Z at once so pairs drive high early
    assign hiz_phase = pwr inside {cospd_pkg::PWR_PARKED, cospd_pkg::PWR_OFF};

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            stop_active <= 1'b0;
        else if (cmpl_fall)
            stop_active <= ~test_and_stop_control[`COSPD_B6_STOP_N];
    end

    genvar gi;
    generate
        for (gi = 0; gi < `COSPD_NUM_STOPPABLE; gi++)
        begin : g_stop
            always_ff @(posedge mclk or negedge rst_b)
            begin
                if (!rst_b)
                    bus_clk_stop_gate[gi] <= 1'b0;
                else
                    bus_clk_stop_gate[gi] <= stop_active & bus_clk_stoppable[gi];
            end
        end
    endgenerate

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            bus_clock_stop_request <= 1'b0;
            bus_ref_stop_hiz <= 1'b0;
            cpu_diff_park <= 3'h0;
            cpu_diff_hiz <= 3'h0;
            bus_ref_park <= 1'b0;
            bus_ref_hiz <= 1'b0;
            single_ended_hold_low <= 1'b1;
            osc_enable <= 1'b1;
            pll_enable <= 1'b1;
            clocks_enable <= 1'b0;
            power_down_state <= 1'b0;
            test_mode_active <= 1'b0;
            test_ref_div_sel <= 1'b0;
            ref_drive_high <= 1'b1;
        end
        else
        begin
            bus_clock_stop_request <= stop_active;
            bus_ref_stop_hiz <= stop_active & drive_mode_control[`COSPD_B5_STOP_HIZ];
            cpu_diff_park <= {3{parked}};
            cpu_diff_hiz <= {3{hiz_phase}} & drive_mode_control[2:0];
            bus_ref_park <= parked;
            bus_ref_hiz <= hiz_phase & drive_mode_control[`COSPD_B5_REF_DOWN_HIZ];
            single_ended_hold_low <= (pwr != cospd_pkg::PWR_RUN);
            osc_enable <= (pwr != cospd_pkg::PWR_OFF);
            pll_enable <= (pwr != cospd_pkg::PWR_OFF);
            clocks_enable <= (pwr == cospd_pkg::PWR_RUN);
            power_down_state <= pwr inside {cospd_pkg::PWR_HOLD, cospd_pkg::PWR_PARKED, cospd_pkg::PWR_OFF};
            test_mode_active <= test_and_stop_control[`COSPD_B6_TEST_EN];
            test_ref_div_sel <= test_and_stop_control[`COSPD_B6_REF_DIV];
            ref_drive_high <= test_and_stop_control[`COSPD_B6_REF_STRONG];
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    chk_down_two_rises: assert property (
        pwr == cospd_pkg::PWR_RUN ##1 pwr == cospd_pkg::PWR_HOLD |-> $past(down_cnt) == `COSPD_DOWN_EDGES)
        else $error("power-down taken before two high rises");
    chk_park_at_fall: assert property (
        $rose(pwr == cospd_pkg::PWR_PARKED) |-> $past(cmpl_fall) ##1 cpu_diff_park == 3'h7)
        else $error("pairs not parked at complement fall");
    chk_osc_after_park: assert property (
        $fell(osc_enable) |-> cpu_diff_park == 3'h7 && bus_ref_park && single_ended_hold_low)
        else $error("oscillator stopped before clocks parked");
    chk_hiz_mode: assert property (
        pwr == cospd_pkg::PWR_OFF |=>
            cpu_diff_park == 3'h7 && (cpu_diff_hiz & ~$past(drive_mode_control[2:0])) == 3'h0)
        else $error("driven-mode pair left high impedance");
    chk_hiz_release: assert property (
        pwr == cospd_pkg::PWR_OFF && !pin_s |-> ##[1:3] cpu_diff_hiz == 3'h0 && !bus_ref_hiz)
        else $error("high-Z pairs not driven after wake");
    chk_wake_bound: assert property (
        pwr == cospd_pkg::PWR_WAKE |-> wait_cnt < `COSPD_WAIT_W'(LATENCY_CYC))
        else $error("wake latency exceeded");
    chk_stop_sync: assert property (
        $changed(stop_active) |-> $past(cmpl_fall))
        else $error("bus stop changed off a clock low edge");
    chk_stop_gate: assert property (
        bus_clk_stop_gate != '0 |-> (bus_clk_stop_gate & ~$past(bus_clk_stoppable)) == '0)
        else $error("free-running output stopped");
    chk_fs_readonly: assert property (
        $changed(fs_latch) |-> $past(pwr) == cospd_pkg::PWR_WAIT_GOOD)
        else $error("frequency selects changed after power-good");
    chk_all_enable: assert property (
        $rose(clocks_enable) |-> !single_ended_hold_low ##1 clocks_enable)
        else $error("outputs not enabled together");

    cov_power_down: cover property (pwr == cospd_pkg::PWR_OFF);
    cov_wake_run: cover property (pwr == cospd_pkg::PWR_WAKE ##1 pwr == cospd_pkg::PWR_RUN);
    cov_reg_write: cover property (wr_strobe && ptr == `COSPD_REG_TEST);
    cov_reg_read: cover property (smb == cospd_pkg::SMB_TX);

endmodule : cospd_ctrl

// file: verif/cospd_host_model.sv
`timescale 1ns/1ps
`include "cospd_map.svh"
// ----------------------------------------
// Management host and platform power pin
// ----------------------------------------
module cospd_host_model (
    input wire logic mclk,
    input wire logic smb_data_oe,
    output logic smb_clk,
    output logic smb_data_line,
    output logic supply_good_strobe
);
    logic host_sda;

    // Wire-and with pull-up: either party may pull low
    assign smb_data_line = host_sda & ~smb_data_oe;

    initial
    begin
        host_sda = 1'h1;
        smb_clk = 1'h1;
        supply_good_strobe = 1'h1;
    end

    // Six cycles a phase, above the four the slave needs
    task automatic ph;
        repeat (6) @(negedge mclk);
    endtask : ph

    task automatic bit_x(input logic b, output logic seen);
        host_sda = b;
        ph();
        smb_clk = 1'h1;
        ph();
        seen = smb_data_line;
        smb_clk = 1'h0;
    endtask : bit_x

    task automatic start_c;
        host_sda = 1'h1;
        ph();
        smb_clk = 1'h1;
        ph();
        host_sda = 1'h0;
        ph();
        smb_clk = 1'h0;
    endtask : start_c

    task automatic stop_c;
        host_sda = 1'h0;
        ph();
        smb_clk = 1'h1;
        ph();
        host_sda = 1'h1;
        ph();
    endtask : stop_c

    task automatic send_byte(input logic [7:0] v, output logic ack);
        logic seen;
        for (int i = 7; i >= 0; i--)
            bit_x(v[i], seen);
        bit_x(1'h1, seen);
        ack = ~seen;
    endtask : send_byte

    task automatic write_reg(input logic [6:0] dev, input logic [7:0] cmd, input logic [7:0] data,
                             output logic [2:0] acks);
        start_c();
        send_byte({dev, 1'h0}, acks[2]);
        send_byte(cmd, acks[1]);
        send_byte(data, acks[0]);
        stop_c();
    endtask : write_reg

    task automatic read_reg(input logic [7:0] cmd, output logic [7:0] data, output logic [2:0] acks);
        logic seen;
        start_c();
        send_byte({`COSPD_SLAVE_ADDR, 1'h0}, acks[2]);
        send_byte(cmd, acks[1]);
        start_c();
        send_byte({`COSPD_SLAVE_ADDR, 1'h1}, acks[0]);
        for (int i = 7; i >= 0; i--)
            bit_x(1'h1, data[i]);
        // Single byte only: not-acknowledge, then stop
        bit_x(1'h1, seen);
        stop_c();
    endtask : read_reg

    task automatic drive_pin(input logic lvl);
        supply_good_strobe = lvl;
    endtask : drive_pin
endmodule : cospd_host_model

// file: verif/clock_output_stop_powerdown_ctrl_tb.sv
`timescale 1ns/1ps
`include "cospd_map.svh"
`define CHECK(what, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) \
        begin \
            bad_count++; \
            $display("Error %s expected %h seen %h", what, exp, got); \
        end \
    end
module clock_output_stop_powerdown_ctrl_tb;
    localparam int LAT = 50;
    logic mclk = 1'h0;
    logic rst_b = 1'h0;
    logic cpu_c = 1'h0;
    logic pll_lock = 1'h0;
    logic [2:0] fs = 3'h5;
    logic [9:0] stoppable = 10'h2A5;
    logic smb_clk, smb_line, sda_out, sda_oe, pin, stop_req, ref_stop_hiz, ref_park, ref_hiz;
    logic hold_low, osc_en, pll_en, clk_en, down_state, test_mode, div_sel, ref_strong;
    logic [2:0] cpu_park;
    logic [2:0] cpu_hiz;
    logic [9:0] gate;
    logic [2:0] acks;
    logic [7:0] rd;
    int bad_count = 0;
    int check_count = 0;
    int n;

    cospd_host_model host (.mclk(mclk), .smb_data_oe(sda_oe), .smb_clk(smb_clk), .smb_data_line(smb_line),
        .supply_good_strobe(pin));

    cospd_ctrl #(.LATENCY_CYC(LAT)) dut (
        .mclk(mclk), .rst_b(rst_b), .smb_clk(smb_clk), .smb_data_in(smb_line), .smb_data_out(sda_out),
        .smb_data_oe(sda_oe), .supply_good_strobe(pin), .processor_complement_clock(cpu_c),
        .pll_lock(pll_lock), .freq_select_a(fs[0]), .freq_select_b(fs[1]), .freq_select_c(fs[2]),
        .bus_clk_stoppable(stoppable), .bus_clk_stop_gate(gate), .bus_clock_stop_request(stop_req),
        .bus_ref_stop_hiz(ref_stop_hiz), .cpu_diff_park(cpu_park), .cpu_diff_hiz(cpu_hiz),
        .bus_ref_park(ref_park), .bus_ref_hiz(ref_hiz), .single_ended_hold_low(hold_low),
        .osc_enable(osc_en), .pll_enable(pll_en), .clocks_enable(clk_en), .power_down_state(down_state),
        .test_mode_active(test_mode), .test_ref_div_sel(div_sel), .ref_drive_high(ref_strong));

    initial
    begin
        forever #10 mclk = ~mclk;
    end

    // Complement clock at a tenth of the rate, edges land on falling mclk edges
    initial
    begin
        forever #100 cpu_c = ~cpu_c;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : final_report

    function automatic logic probe(input int k);
        case (k)
            0: probe = stop_req;
            1: probe = down_state;
            2: probe = osc_en;
            default: probe = clk_en;
        endcase
    endfunction : probe

    task automatic wait_for(input int k, input logic lvl);
        n = 0;
        while (probe(k) !== lvl && n < 2000)
        begin
            @(negedge mclk);
            n++;
        end
        if (n >= 2000)
        begin
            bad_count++;
            $display("Error wait %0d expected %h seen timeout", k, lvl);
            final_report();
        end
    endtask : wait_for

    task automatic reg_write(input logic [7:0] cmd, input logic [7:0] data);
        host.write_reg(`COSPD_SLAVE_ADDR, cmd, data, acks);
        `CHECK("write acks", 3'h7, acks)
    endtask : reg_write

    task automatic reg_check(input string what, input logic [7:0] cmd, input logic [7:0] exp);
        host.read_reg(cmd, rd, acks);
        `CHECK("read acks", 3'h7, acks)
        `CHECK(what, exp, rd)
    endtask : reg_check

    initial
    begin
        repeat (8) @(negedge mclk);
        rst_b = 1'h1;
        repeat (4) @(negedge mclk);
        // Early power-down must wait for the run state; no lock, so wake by timeout
        host.drive_pin(1'h0);
        repeat (20) @(negedge mclk);
        host.drive_pin(1'h1);
        wait_for(1, 1'h1);
        `CHECK("early request held off", 1'h1, n > 25)
        wait_for(2, 1'h0);
        host.drive_pin(1'h0);
        wait_for(3, 1'h1);
        `CHECK("wake by timeout", 1'h1, n >= LAT)
        $display("test power_good_start done");
        pll_lock = 1'h1;
        reg_check("drive reset", 8'h05, 8'h00);
        reg_check("test reset", 8'h06, 8'h1D);
        reg_check("identity", 8'h07, {`COSPD_REV_CODE, `COSPD_MAKER_CODE});
        `CHECK("strength reset", 1'h1, ref_strong)
        `CHECK("drain value", 1'h0, sda_out)
        reg_write(8'h05, 8'hFF);
        reg_check("drive mask", 8'h05, 8'h8F);
        reg_write(8'h07, 8'h00);
        reg_check("identity kept", 8'h07, {`COSPD_REV_CODE, `COSPD_MAKER_CODE});
        reg_write(8'h06, 8'hFF);
        `CHECK("test mode", 1'h1, test_mode)
        `CHECK("divided clock", 1'h1, div_sel)
        reg_check("test readback", 8'h06, 8'hDD);
        reg_write(8'h06, 8'h48);
        `CHECK("high-z select", 1'h0, div_sel)
        `CHECK("weak drive", 1'h0, ref_strong)
        reg_check("test written", 8'h06, 8'h4D);
        reg_write(8'h06, 8'h18);
        `CHECK("normal mode", 1'h0, test_mode)
        reg_check("unknown code", 8'h10, 8'h00);
        host.write_reg(7'h2C, 8'h05, 8'h00, acks);
        `CHECK("foreign address", 1'h0, acks[2])
        reg_check("drive untouched", 8'h05, 8'h8F);
        $display("test registers done");
        reg_write(8'h06, 8'h10);
        wait_for(0, 1'h1);
        @(negedge mclk);
        `CHECK("stop gate", 10'h2A5, gate)
        `CHECK("stop high-z", 1'h1, ref_stop_hiz)
        reg_write(8'h06, 8'h18);
        wait_for(0, 1'h0);
        @(negedge mclk);
        `CHECK("restart gate", 10'h000, gate)
        `CHECK("restart high-z", 1'h0, ref_stop_hiz)
        $display("test bus_clock_stop done");
        reg_write(8'h05, 8'h0D);
        host.drive_pin(1'h1);
        wait_for(1, 1'h1);
        `CHECK("held low", 1'h1, hold_low)
        `CHECK("osc on while parking", 1'h1, osc_en)
        wait_for(2, 1'h0);
        `CHECK("park time", 1'h1, n < 40)
        `CHECK("cpu park", 3'h7, cpu_park)
        `CHECK("cpu high-z", 3'h5, cpu_hiz)
        `CHECK("ref park", 2'h3, {ref_park, ref_hiz})
        `CHECK("pll off", 1'h0, pll_en)
        `CHECK("clocks off", 1'h0, clk_en)
        host.drive_pin(1'h0);
        wait_for(3, 1'h1);
        `CHECK("wake on lock", 1'h1, n < LAT)
        `CHECK("high-z released", 4'h0, {ref_hiz, cpu_hiz})
        `CHECK("run outputs", 4'h3, {down_state, hold_low, osc_en, pll_en})
        $display("test power_down done");
        final_report();
    end
endmodule : clock_output_stop_powerdown_ctrl_tb
